// ### core/sample_storage_buffer_params.svh
`ifndef SAMPLE_STORAGE_BUFFER_PARAMS_SVH
`define SAMPLE_STORAGE_BUFFER_PARAMS_SVH

// Buffer geometry: entries, last index, full count
`define BUF_DEPTH 14'h1fff
`define BUF_LAST 13'h1ffe
`define BUF_FULL 13'h1fff
`define BUF_ZERO 13'h0000

// Timing
`define CLK_HZ 100000000
`define BASE_RATE_HZ 512
`define RATE_DIV_MAX 13'h1fff
`define RATE_SOFT_SAMPLE_STROBE 4'he

// Register byte offsets
`define REG_CTRL 8'h00
`define REG_CMD 8'h04
`define REG_STATUS 8'h08
`define REG_BIN_SEL 8'h0c
`define REG_BIN_DATA 8'h10

// Control fields and reset value (loop mode, fastest internal rate)
`define CTRL_LOOP 0
`define CTRL_EXT_START 1
`define CTRL_RATE_LO 4
`define CTRL_RATE_HI 7
`define CTRL_RESET 8'hd1

// Command bits
`define CMD_BEGIN 0
`define CMD_HOLD 1
`define CMD_CLEAR 2
`define CMD_SOFT_SOFT_SAMPLE_STROBE 3

// Status fields
`define STAT_STATE_HI 2
`define STAT_COUNT_LO 16
`define STAT_COUNT_HI 28

// Bus responses
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`endif

// ### core/sample_storage_buffer_pkg.sv
package sample_storage_buffer_pkg;
   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_RUN = 3'b010,
      ST_PAUSED = 3'b100
   } cap_state_t;
endpackage

// ### core/sample_storage_buffer.sv
// Contract
// - Buffer holds up to 8191 first-channel points.
// - Power-up leaves buffer empty.
// - Store displayed value only, already scaled.
// - Bin 0 oldest, bin N-1 newest.
// - Internal rate appends one point per period.
// - One common strobe samples all channels.
// - Trigger rate samples within 2 ms.
// - Ignore edges faster than 512 Hz.
// - Single pass stops when full, sounds alarm.
// - Loop mode overwrites, keeps latest 8191.
// - Wrapped loop: bin 0 oldest, 8190 newest.
// - End mode defaults to loop.
// - Start command begins or resumes storage.
// - Hold freezes points and write position.
// - Clear halts storage and empties buffer.
// - Trigger-start edge acts as start command.
// - Trigger-start, internal rate: edge only starts.
// - Trigger-start, trigger rate: first edge starts.
// - Buffer readable only over host interface.
// - Start ignored while storage running.
// - Hold ignored when paused or reset.
// - Soft trigger equals external trigger edge.
`timescale 1ns/1ps
`include "sample_storage_buffer_params.svh"

module sample_storage_buffer
   import sample_storage_buffer_pkg::*;
#(
   parameter int TICK_CYCLES = `CLK_HZ / `BASE_RATE_HZ
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // AXI4-Lite write
   input wire logic [7:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   // AXI4-Lite read
   input wire logic [7:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   // Capture
   input wire logic [31:0] sample_value,
   input wire logic soft_sample_strobe_in,
   output logic sample_strobe,
   output logic alarm_pulse
);

   logic [31:0] mem [0:8190];
   cap_state_t state_q;
   logic [12:0] wr_idx_q;
   logic [12:0] count_q;
   logic [7:0] ctrl_q;
   logic [12:0] bin_sel_q;
   logic aw_hold_q;
   logic w_hold_q;
   logic [7:0] awaddr_q;
   logic [31:0] wdata_q;
   logic [3:0] wstrb_q;
   logic bvalid_q;
   logic [1:0] bresp_q;
   logic rvalid_q;
   logic [31:0] rdata_q;
   logic [1:0] rresp_q;
   logic soft_sample_strobe_s1_q;
   logic soft_sample_strobe_s2_q;
   logic soft_sample_strobe_s3_q;
   logic [17:0] tick_cnt_q;
   logic [12:0] div_cnt_q;
   logic [17:0] holdoff_q;
   logic sample_strobe_q;
   logic alarm_q;

   logic wr_fire;
   logic cmd_wr;
   logic begin_cmd;
   logic hold_capture_cmd;
   logic clear_buffer_cmd;
   logic soft_sample_strobe;
   logic loop_mode;
   logic ext_edge_start_select;
   logic [3:0] rate_sel;
   logic soft_sample_strobe_rate;
   logic soft_sample_strobe_acc;
   logic start_ev;
   logic base_tick;
   logic rate_tick;
   logic sample_ev;
   logic full;
   logic append;
   logic [13:0] phys_sum;
   logic [12:0] phys_idx;

   assign loop_mode = ctrl_q[`CTRL_LOOP];
   assign ext_edge_start_select = ctrl_q[`CTRL_EXT_START];
   assign rate_sel = ctrl_q[`CTRL_RATE_HI:`CTRL_RATE_LO];
   assign soft_sample_strobe_rate = rate_sel >= `RATE_SOFT_SAMPLE_STROBE;
   assign full = count_q == `BUF_FULL;

   // Register write path: address and data may arrive in either order
   assign awready = !aw_hold_q && !bvalid_q;
   assign wready = !w_hold_q && !bvalid_q;
   assign bvalid = bvalid_q;
   assign bresp = bresp_q;
   assign wr_fire = aw_hold_q && w_hold_q;
   assign cmd_wr = wr_fire && awaddr_q == `REG_CMD && wstrb_q[0];
   assign begin_cmd = cmd_wr && wdata_q[`CMD_BEGIN];
   assign hold_capture_cmd = cmd_wr && wdata_q[`CMD_HOLD];
   assign clear_buffer_cmd = cmd_wr && wdata_q[`CMD_CLEAR];
   assign soft_sample_strobe = cmd_wr && wdata_q[`CMD_SOFT_SOFT_SAMPLE_STROBE];

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         aw_hold_q <= 1'b0;
         w_hold_q <= 1'b0;
         awaddr_q <= 8'h00;
         wdata_q <= 32'h0000_0000;
         wstrb_q <= 4'h0;
         bvalid_q <= 1'b0;
         bresp_q <= `RESP_OKAY;
      end else begin
         if (awvalid && awready) begin
            aw_hold_q <= 1'b1;
            awaddr_q <= awaddr;
         end
         if (wvalid && wready) begin
            w_hold_q <= 1'b1;
            wdata_q <= wdata;
            wstrb_q <= wstrb;
         end
         if (wr_fire) begin
            aw_hold_q <= 1'b0;
            w_hold_q <= 1'b0;
            bvalid_q <= 1'b1;
            case (awaddr_q)
               `REG_CTRL, `REG_CMD, `REG_BIN_SEL: bresp_q <= `RESP_OKAY;
               default: bresp_q <= `RESP_SLVERR;
            endcase
         end else if (bvalid_q && bready) begin
            bvalid_q <= 1'b0;
         end
      end
   end

   // Software-visible configuration
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_q <= `CTRL_RESET;
         bin_sel_q <= `BUF_ZERO;
      end else if (wr_fire) begin
         if (awaddr_q == `REG_CTRL && wstrb_q[0]) begin
            ctrl_q <= wdata_q[7:0];
         end
         if (awaddr_q == `REG_BIN_SEL) begin
            if (wstrb_q[0]) begin
               bin_sel_q[7:0] <= wdata_q[7:0];
            end
            if (wstrb_q[1]) begin
               bin_sel_q[12:8] <= wdata_q[12:8];
            end
         end
      end
   end

   // Bin to entry: once wrapped the oldest point sits at the write index
   assign phys_sum = {1'b0, wr_idx_q} + {1'b0, bin_sel_q};
   always_comb begin
      phys_idx = bin_sel_q;
      if (full) begin
         phys_idx = (phys_sum >= `BUF_DEPTH) ? 13'(phys_sum - `BUF_DEPTH) : phys_sum[12:0];
      end
   end

   // Register read path; the buffer is reachable from here only
   assign arready = !rvalid_q;
   assign rvalid = rvalid_q;
   assign rdata = rdata_q;
   assign rresp = rresp_q;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rvalid_q <= 1'b0;
         rdata_q <= 32'h0000_0000;
         rresp_q <= `RESP_OKAY;
      end else if (arvalid && arready) begin
         rvalid_q <= 1'b1;
         rresp_q <= `RESP_OKAY;
         rdata_q <= 32'h0000_0000;
         case (araddr)
            `REG_CTRL: rdata_q[7:0] <= ctrl_q;
            `REG_CMD: rdata_q <= 32'h0000_0000;
            `REG_STATUS: begin
               rdata_q[`STAT_STATE_HI:0] <= state_q;
               rdata_q[`STAT_COUNT_HI:`STAT_COUNT_LO] <= count_q;
            end
            `REG_BIN_SEL: rdata_q[12:0] <= bin_sel_q;
            `REG_BIN_DATA: begin
               // Bins at or above the count hold nothing and read as zero
               if (bin_sel_q < count_q) begin
                  rdata_q <= mem[phys_idx];
               end
            end
            default: rresp_q <= `RESP_SLVERR;
         endcase
      end else if (rvalid_q && rready) begin
         rvalid_q <= 1'b0;
      end
   end

   // Trigger pin synchroniser and edge detect
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         soft_sample_strobe_s1_q <= 1'b0;
         soft_sample_strobe_s2_q <= 1'b0;
         soft_sample_strobe_s3_q <= 1'b0;
      end else begin
         soft_sample_strobe_s1_q <= soft_sample_strobe_in;
         soft_sample_strobe_s2_q <= soft_sample_strobe_s1_q;
         soft_sample_strobe_s3_q <= soft_sample_strobe_s2_q;
      end
   end

   // Holdoff of one 512 Hz period after each accepted trigger
   assign soft_sample_strobe_acc = ((soft_sample_strobe_s2_q && !soft_sample_strobe_s3_q) || soft_sample_strobe) && holdoff_q == 18'h00000;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         holdoff_q <= 18'h00000;
      end else if (soft_sample_strobe_acc) begin
         holdoff_q <= 18'(TICK_CYCLES - 1);
      end else if (holdoff_q != 18'h00000) begin
         holdoff_q <= holdoff_q - 18'h00001;
      end
   end

   // Internal rate: 512 Hz base tick divided by a power of two
   assign base_tick = tick_cnt_q == 18'(TICK_CYCLES - 1);
   assign rate_tick = base_tick && div_cnt_q == (`RATE_DIV_MAX >> rate_sel);

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tick_cnt_q <= 18'h00000;
         div_cnt_q <= `BUF_ZERO;
      end else if (state_q != ST_RUN) begin
         // Restart the period so the first sample lands one period after start
         tick_cnt_q <= 18'h00000;
         div_cnt_q <= `BUF_ZERO;
      end else if (base_tick) begin
         tick_cnt_q <= 18'h00000;
         div_cnt_q <= rate_tick ? `BUF_ZERO : div_cnt_q + 13'h0001;
      end else begin
         tick_cnt_q <= tick_cnt_q + 18'h00001;
      end
   end

   // A trigger only samples once running, so a starting edge never samples
   assign sample_ev = soft_sample_strobe_rate ? soft_sample_strobe_acc : rate_tick;
   assign start_ev = begin_cmd || (ext_edge_start_select && soft_sample_strobe_acc);
   assign append = state_q == ST_RUN && sample_ev && !hold_capture_cmd && !clear_buffer_cmd
      && !(full && !loop_mode);

   // Capture state
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= ST_IDLE;
      end else if (clear_buffer_cmd) begin
         state_q <= ST_IDLE;
      end else begin
         case (state_q)
            ST_IDLE, ST_PAUSED: begin
               if (start_ev) begin
                  state_q <= ST_RUN;
               end
            end
            ST_RUN: begin
               if (hold_capture_cmd) begin
                  state_q <= ST_PAUSED;
               end else if (!loop_mode && (full || (append && count_q == `BUF_LAST))) begin
                  state_q <= ST_PAUSED;
               end
            end
            default: state_q <= ST_IDLE;
         endcase
      end
   end

   // Write index and point count
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_idx_q <= `BUF_ZERO;
         count_q <= `BUF_ZERO;
      end else if (clear_buffer_cmd) begin
         wr_idx_q <= `BUF_ZERO;
         count_q <= `BUF_ZERO;
      end else if (append) begin
         wr_idx_q <= (wr_idx_q == `BUF_LAST) ? `BUF_ZERO : wr_idx_q + 13'h0001;
         count_q <= full ? count_q : count_q + 13'h0001;
      end
   end

   // Storage array is not reset; the count alone decides what is valid
   always_ff @(posedge clk) begin
      if (append) begin
         mem[wr_idx_q] <= sample_value;
      end
   end

   // Common strobe for every display channel, and end-of-capture alarm
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sample_strobe_q <= 1'b0;
         alarm_q <= 1'b0;
      end else begin
         sample_strobe_q <= append;
         alarm_q <= append && !loop_mode && count_q == `BUF_LAST;
      end
   end

   assign sample_strobe = sample_strobe_q;
   assign alarm_pulse = alarm_q;

   property p_clear_empties;
      @(posedge clk) disable iff (!rst_n)
      clear_buffer_cmd |=> count_q == `BUF_ZERO && state_q == ST_IDLE;
   endproperty
   a_clear_empties: assert property (p_clear_empties) else $error("clear left points behind");

   property p_hold_freezes;
      @(posedge clk) disable iff (!rst_n)
      state_q == ST_RUN && hold_capture_cmd && !clear_buffer_cmd
         |=> state_q == ST_PAUSED && $stable(count_q) && $stable(wr_idx_q);
   endproperty
   a_hold_freezes: assert property (p_hold_freezes) else $error("hold did not freeze buffer");

   property p_start_ignored;
      @(posedge clk) disable iff (!rst_n)
      state_q == ST_RUN && begin_cmd && !hold_capture_cmd && !clear_buffer_cmd
         && (loop_mode || count_q < `BUF_LAST)
         |=> state_q == ST_RUN;
   endproperty
   a_start_ignored: assert property (p_start_ignored) else $error("start disturbed running capture");

   property p_hold_ignored;
      @(posedge clk) disable iff (!rst_n)
      state_q != ST_RUN && hold_capture_cmd && !start_ev && !clear_buffer_cmd |=> $stable(state_q);
   endproperty
   a_hold_ignored: assert property (p_hold_ignored) else $error("hold acted while not running");

   property p_append_grows;
      @(posedge clk) disable iff (!rst_n)
      append && !full |=> count_q == $past(count_q) + 13'h0001 && sample_strobe;
   endproperty
   a_append_grows: assert property (p_append_grows) else $error("append did not add a point");

   property p_single_stop;
      @(posedge clk) disable iff (!rst_n)
      append && !loop_mode && count_q == `BUF_LAST |=> alarm_pulse && full && state_q == ST_PAUSED;
   endproperty
   a_single_stop: assert property (p_single_stop) else $error("single pass did not stop");

   property p_loop_keeps;
      @(posedge clk) disable iff (!rst_n)
      append && full |=> full && wr_idx_q != $past(wr_idx_q);
   endproperty
   a_loop_keeps: assert property (p_loop_keeps) else $error("loop mode lost its wrap");

   property p_soft_sample_strobe_sample;
      @(posedge clk) disable iff (!rst_n)
      state_q == ST_RUN && soft_sample_strobe_rate && soft_sample_strobe_s2_q && !soft_sample_strobe_s3_q && holdoff_q == 18'h00000
         && !cmd_wr && (loop_mode || !full) |-> ##1 sample_strobe;
   endproperty
   a_soft_sample_strobe_sample: assert property (p_soft_sample_strobe_sample) else $error("trigger did not sample");

   property p_holdoff;
      @(posedge clk) disable iff (!rst_n)
      soft_sample_strobe_acc |=> !soft_sample_strobe_acc [*7];
   endproperty
   a_holdoff: assert property (p_holdoff) else $error("trigger accepted inside holdoff");

   property p_count_bound;
      @(posedge clk) disable iff (!rst_n)
      wr_idx_q <= `BUF_LAST && (full || wr_idx_q == count_q);
   endproperty
   a_count_bound: assert property (p_count_bound) else $error("write index out of step");

endmodule // sample_storage_buffer

// ### verification/soft_sample_strobe_source.sv
`timescale 1ns/1ps
module soft_sample_strobe_source (
   // Clock
   input wire logic clk,
   // Request from the bench, one cycle per edge wanted
   input wire logic fire,
   // Trigger pin, idles low
   output logic soft_sample_strobe_in
);
   initial soft_sample_strobe_in = 1'b0;
   // Registered so the pin moves just after an edge, never at it
   always @(posedge clk) begin
      soft_sample_strobe_in <= fire;
   end
endmodule // soft_sample_strobe_source

// ### verification/tb.sv
`timescale 1ns/1ps
module tb;
   import sample_storage_buffer_pkg::*;
   localparam int TK = 8;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [7:0] awaddr = 8'h00;
   logic [7:0] araddr = 8'h00;
   logic awvalid = 1'b0;
   logic wvalid = 1'b0;
   logic arvalid = 1'b0;
   logic fire = 1'b0;
   logic [31:0] wdata = 32'h0;
   logic [31:0] sample_value = 32'h0;
   logic [31:0] seed = 32'heb8f9ab2;
   logic [31:0] rd, prev_sv, rdata;
   logic [1:0] bresp, rresp, rs;
   logic awready, wready, bvalid, arready, rvalid, sample_strobe, alarm_pulse, soft_sample_strobe_in;
   int mismatches = 0;
   int comparisons = 0;
   int cyc = 0;
   int last_t = 0;
   int gap = 0;
   int nstb = 0;
   int nalm = 0;
   int n;
   logic [31:0] hist[$];

   always #5 clk = ~clk;

   sample_storage_buffer #(.TICK_CYCLES(TK)) DUT (
      .clk(clk), .rst_n(rst_n), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
      .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid), .wready(wready), .bresp(bresp),
      .bvalid(bvalid), .bready(1'b1), .araddr(araddr), .arvalid(arvalid), .arready(arready),
      .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(1'b1), .sample_value(sample_value),
      .soft_sample_strobe_in(soft_sample_strobe_in), .sample_strobe(sample_strobe), .alarm_pulse(alarm_pulse));

   soft_sample_strobe_source PTN (.clk(clk), .fire(fire), .soft_sample_strobe_in(soft_sample_strobe_in));

   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   // Strobe lands one edge after the store, so the stored value is last edge's input
   always @(posedge clk) begin
      if (sample_strobe === 1'b1) begin
         hist.push_back(prev_sv);
         gap = cyc - last_t;
         last_t = cyc;
         nstb++;
      end
      if (alarm_pulse === 1'b1) nalm++;
      prev_sv = sample_value;
      sample_value <= xs();
      cyc++;
   end

   task automatic give_verdict();
      $display("comparisons=%0d mismatches=%0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask

   task automatic to();
      mismatches++;
      give_verdict();
   endtask

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      comparisons++;
      if (g !== e) begin
         mismatches++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask

   task automatic chk_r(input logic [1:0] g, input logic [1:0] e);
      chk({30'h0, g}, {30'h0, e});
   endtask

   // Handshakes are judged at the falling edge, acted on at the next rising one
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bit ta, tw, done;
      int i;
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      done = 0;
      i = 0;
      while (!done) begin
         @(negedge clk);
         ta = awvalid && awready;
         tw = wvalid && wready;
         done = bvalid;
         rs = bresp;
         @(posedge clk);
         if (ta) awvalid <= 1'b0;
         if (tw) wvalid <= 1'b0;
         if (++i > 100) to();
      end
   endtask

   task automatic rdr(input logic [7:0] a);
      bit t, done;
      int i;
      araddr <= a;
      arvalid <= 1'b1;
      done = 0;
      i = 0;
      while (!done) begin
         @(negedge clk);
         t = arvalid && arready;
         done = rvalid;
         rd = rdata;
         rs = rresp;
         @(posedge clk);
         if (t) arvalid <= 1'b0;
         if (++i > 100) to();
      end
   endtask

   task automatic st(input cap_state_t s, input int c);
      rdr(8'h08);
      chk({29'h0, rd[2:0]}, {29'h0, s});
      if (c >= 0) chk({19'h0, rd[28:16]}, 32'(c));
   endtask

   // Bin k of a buffer holding c points is the k-th oldest of the last c strobed
   task automatic bin(input int k, input int c);
      wr(8'h0c, 32'(k));
      rdr(8'h10);
      chk(rd, hist[hist.size() - c + k]);
   endtask

   task automatic wait_stb(input int c);
      int i;
      i = 0;
      while (nstb < c) begin
         @(negedge clk);
         if (++i > 70000) to();
      end
      @(posedge clk);
   endtask

   task automatic pulse();
      fire <= 1'b1;
      @(posedge clk);
      fire <= 1'b0;
      @(posedge clk);
   endtask

   initial begin
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      rdr(8'h00);
      chk(rd, 32'h0000_00d1);
      st(ST_IDLE, 0);
      wr(8'h40, 32'h1);
      chk_r(rs, 2'b10);
      rdr(8'h40);
      chk_r(rs, 2'b10);
      chk(rd, 32'h0);
      // Single pass at the fastest internal rate
      wr(8'h00, 32'hd0);
      wr(8'h04, 32'h1);
      wr(8'h04, 32'h1);
      st(ST_RUN, -1);
      wait_stb(8191);
      repeat (4 * TK) @(posedge clk);
      chk(32'(nalm), 32'h1);
      chk(32'(nstb), 32'd8191);
      st(ST_PAUSED, 8191);
      chk(32'(gap), 32'(TK));
      bin(0, 8191);
      bin(8190, 8191);
      wr(8'h04, 32'h2);
      st(ST_PAUSED, 8191);
      // Switching to loop and resuming from full forces a wrap
      wr(8'h00, 32'hd1);
      wr(8'h04, 32'h1);
      wait_stb(8191 + 5);
      wr(8'h04, 32'h2);
      n = nstb;
      repeat (4 * TK) @(posedge clk);
      chk(32'(nstb), 32'(n));
      st(ST_PAUSED, 8191);
      bin(0, 8191);
      bin(8190, 8191);
      bin(int'(xs() % 32'd8191), 8191);
      wr(8'h04, 32'h4);
      st(ST_IDLE, 0);
      wr(8'h04, 32'h2);
      st(ST_IDLE, 0);
      // Slower internal rate, four times the base period
      wr(8'h00, 32'hb1);
      wr(8'h04, 32'h1);
      wait_stb(nstb + 3);
      chk(32'(gap), 32'(4 * TK));
      wr(8'h04, 32'h4);
      // Trigger start with trigger rate
      wr(8'h00, 32'he3);
      pulse();
      repeat (6) @(posedge clk);
      st(ST_RUN, 0);
      repeat (TK) @(posedge clk);
      n = nstb;
      pulse();
      pulse();
      repeat (2 * TK) @(posedge clk);
      chk(32'(nstb), 32'(n + 1));
      st(ST_RUN, 1);
      bin(0, 1);
      wr(8'h04, 32'h8);
      repeat (TK) @(posedge clk);
      st(ST_RUN, 2);
      // Trigger start with internal rate
      wr(8'h04, 32'h4);
      wr(8'h00, 32'hd3);
      pulse();
      repeat (6) @(posedge clk);
      st(ST_RUN, -1);
      wait_stb(nstb + 2);
      chk(32'(gap), 32'(TK));
      give_verdict();
   end
endmodule // tb
